//--- rtl/xfer_pkg.sv
package xfer_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          WORD_W          = 10;
    localparam int          NIB_W           = 4;
    localparam int          BYTE_W          = 8;
    localparam int          NIB_HI_LSB      = 4;
    // Register byte offsets
    localparam logic [7:0]  OFF_INSTR       = 8'h00;
    localparam logic [7:0]  OFF_ACC         = 8'h04;
    localparam logic [7:0]  OFF_REGB        = 8'h08;
    localparam logic [7:0]  OFF_COUNT       = 8'h0C;
    localparam logic [7:0]  OFF_LOW         = 8'h10;
    localparam logic [7:0]  OFF_HIGH        = 8'h14;
    localparam logic [7:0]  OFF_STATUS      = 8'h18;
    localparam logic [7:0]  OFF_RETIRED     = 8'h1C;
    // Status fields
    localparam int          ST_CARRY_BIT    = 0;
    localparam int          ST_SKIP_BIT     = 1;
    // Instruction codes
    localparam logic [9:0]  CODE_LOAD_T2_LOW = 10'h231;
    localparam logic [9:0]  CODE_LOAD_HIGH   = 10'h294;
    localparam logic [9:0]  CODE_RELOAD_CNT  = 10'h295;
    localparam logic [9:0]  CODE_B_TO_ACC    = 10'h01E;
    // Reset values
    localparam logic [9:0]  RST_INSTR       = 10'h000;
    localparam logic [3:0]  RST_NIB         = 4'h0;
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    // Timing: every instruction completes in one cycle
    localparam int          EXEC_CYCLES     = 1;
    localparam logic [7:0]  RETIRE_STEP     = 8'h01;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

//--- rtl/decode_if.sv
`timescale 1ns/1ps
interface decode_if;
    logic [9:0] word;
    logic       op_load_timer2_and_low_reload;
    logic       op_load_high_reload;
    logic       op_copy_low_reload_to_counter;
    logic       op_copy_b_to_acc;
    modport core (
        output word,
        input  op_load_timer2_and_low_reload,
        input  op_load_high_reload,
        input  op_copy_low_reload_to_counter,
        input  op_copy_b_to_acc
    );
    modport dec (
        input  word,
        output op_load_timer2_and_low_reload,
        output op_load_high_reload,
        output op_copy_low_reload_to_counter,
        output op_copy_b_to_acc
    );
endinterface

//--- rtl/xfer_decoder.sv
`timescale 1ns/1ps
module xfer_decoder #(
    parameter logic [9:0] RELOAD_CNT_CODE = xfer_pkg::CODE_RELOAD_CNT
) (
    decode_if.dec dif
);
    import xfer_pkg::*;

    always_comb begin
        // RULE1 combined write code
        dif.op_load_timer2_and_low_reload = (dif.word == CODE_LOAD_T2_LOW);
        // RULE4 high reload code
        dif.op_load_high_reload           = (dif.word == CODE_LOAD_HIGH);
        // RULE5 reload-to-counter code
        dif.op_copy_low_reload_to_counter = (dif.word == RELOAD_CNT_CODE);
        // RULE6 B-to-accumulator code
        dif.op_copy_b_to_acc              = (dif.word == CODE_B_TO_ACC);
    end
endmodule

//--- rtl/xfer_core.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Code 0x231 loads timer 2 and low reload; one word, one cycle.
// RULE2 - That instruction puts register B into bits 7..4 of counter and low latch.
// RULE3 - Same instruction puts accumulator into bits 3..0 of both, simultaneously.
// RULE4 - Code 0x294 loads B:A into high reload latch; counter untouched.
// RULE5 - Reload-to-counter copies all eight low latch bits into counter; latch kept.
// RULE6 - Code 0x01E copies register B into accumulator; B unchanged.
// RULE7 - None alter carry or skip; flow moves to the next word.
module xfer_core #(
    parameter logic [9:0] RELOAD_CNT_CODE = xfer_pkg::CODE_RELOAD_CNT
) (
    input  wire logic                         MCLK,
    input  wire logic                         RST,
    input  wire logic [xfer_pkg::ADDR_W-1:0]  S_AXI_AWADDR,
    input  wire logic                         S_AXI_AWVALID,
    output logic                              S_AXI_AWREADY,
    input  wire logic [xfer_pkg::DATA_W-1:0]  S_AXI_WDATA,
    input  wire logic [3:0]                   S_AXI_WSTRB,
    input  wire logic                         S_AXI_WVALID,
    output logic                              S_AXI_WREADY,
    output logic [1:0]                        S_AXI_BRESP,
    output logic                              S_AXI_BVALID,
    input  wire logic                         S_AXI_BREADY,
    input  wire logic [xfer_pkg::ADDR_W-1:0]  S_AXI_ARADDR,
    input  wire logic                         S_AXI_ARVALID,
    output logic                              S_AXI_ARREADY,
    output logic [xfer_pkg::DATA_W-1:0]       S_AXI_RDATA,
    output logic [1:0]                        S_AXI_RRESP,
    output logic                              S_AXI_RVALID,
    input  wire logic                         S_AXI_RREADY
);
    import xfer_pkg::*;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_have;
        logic [DATA_W-1:0] w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
        logic [9:0]        instr;
        logic              exec;
        logic [3:0]        acc;
        logic [3:0]        regb;
        logic [7:0]        timer2_count_bits;
        logic [7:0]        timer2_low_reload_latch;
        logic [7:0]        timer2_high_reload_latch;
        logic              carry_flag;
        logic              skip_flag;
        logic [7:0]        retired;
    } state_t;

    state_t st_reg;
    state_t st_next;

    decode_if dif ();

    assign dif.word = st_reg.instr;

    xfer_decoder #(
        .RELOAD_CNT_CODE (RELOAD_CNT_CODE)
    ) u_dec (
        .dif (dif)
    );

    always_comb begin
        st_next      = st_reg;
        st_next.exec = 1'b0;

        // One instruction issued per register write; executes the next cycle
        if (st_reg.exec) begin
            // RULE7 sequential flow, one word
            st_next.retired = st_reg.retired + RETIRE_STEP;
            // RULE7 carry kept, no skip
            st_next.skip_flag = 1'b0;
            if (dif.op_load_timer2_and_low_reload) begin
                // RULE2 B into upper nibbles
                st_next.timer2_count_bits[7:4]       = st_reg.regb;
                st_next.timer2_low_reload_latch[7:4] = st_reg.regb;
                // RULE3 A into lower nibbles
                st_next.timer2_count_bits[3:0]       = st_reg.acc;
                st_next.timer2_low_reload_latch[3:0] = st_reg.acc;
            end else if (dif.op_load_high_reload) begin
                // RULE4 B:A into high latch
                st_next.timer2_high_reload_latch = {st_reg.regb, st_reg.acc};
            end else if (dif.op_copy_low_reload_to_counter) begin
                // RULE5 latch copied to counter
                st_next.timer2_count_bits = st_reg.timer2_low_reload_latch;
            end else if (dif.op_copy_b_to_acc) begin
                // RULE6 B copied to accumulator
                st_next.acc = st_reg.regb;
            end
        end

        // Write channel: address and data may arrive in either order
        if (S_AXI_AWVALID && st_reg.awready) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && st_reg.wready) begin
            st_next.w_have = 1'b1;
            st_next.w_data = S_AXI_WDATA;
            st_next.w_strb = S_AXI_WSTRB;
        end
        if (st_reg.bvalid && S_AXI_BREADY) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = RESP_OKAY;
            if (st_reg.aw_addr == OFF_INSTR) begin
                // Word spans two bytes; partial strobes would issue half a code
                if (st_reg.w_strb[1:0] == 2'b11) begin
                    st_next.instr = st_reg.w_data[WORD_W-1:0];
                    st_next.exec  = 1'b1;
                end
            end else if (st_reg.aw_addr == OFF_ACC) begin
                if (st_reg.w_strb[0]) begin
                    st_next.acc = st_reg.w_data[NIB_W-1:0];
                end
            end else if (st_reg.aw_addr == OFF_REGB) begin
                if (st_reg.w_strb[0]) begin
                    st_next.regb = st_reg.w_data[NIB_W-1:0];
                end
            end else if (st_reg.aw_addr == OFF_COUNT) begin
                if (st_reg.w_strb[0]) begin
                    st_next.timer2_count_bits = st_reg.w_data[BYTE_W-1:0];
                end
            end else if (st_reg.aw_addr == OFF_STATUS) begin
                if (st_reg.w_strb[0]) begin
                    st_next.carry_flag = st_reg.w_data[ST_CARRY_BIT];
                end
            end else if (st_reg.aw_addr == OFF_LOW || st_reg.aw_addr == OFF_HIGH
                         || st_reg.aw_addr == OFF_RETIRED) begin
                // Read-only: latches change only through instructions
                st_next.bresp = RESP_OKAY;
            end else begin
                st_next.bresp = RESP_SLVERR;
            end
        end
        st_next.awready = !st_next.aw_have && !st_next.bvalid;
        st_next.wready  = !st_next.w_have && !st_next.bvalid;

        // Read channel
        if (st_reg.rvalid && S_AXI_RREADY) begin
            st_next.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = RESP_OKAY;
            st_next.rdata  = '0;
            if (S_AXI_ARADDR == OFF_INSTR) begin
                st_next.rdata[WORD_W-1:0] = st_reg.instr;
            end else if (S_AXI_ARADDR == OFF_ACC) begin
                st_next.rdata[NIB_W-1:0] = st_reg.acc;
            end else if (S_AXI_ARADDR == OFF_REGB) begin
                st_next.rdata[NIB_W-1:0] = st_reg.regb;
            end else if (S_AXI_ARADDR == OFF_COUNT) begin
                st_next.rdata[BYTE_W-1:0] = st_reg.timer2_count_bits;
            end else if (S_AXI_ARADDR == OFF_LOW) begin
                st_next.rdata[BYTE_W-1:0] = st_reg.timer2_low_reload_latch;
            end else if (S_AXI_ARADDR == OFF_HIGH) begin
                st_next.rdata[BYTE_W-1:0] = st_reg.timer2_high_reload_latch;
            end else if (S_AXI_ARADDR == OFF_STATUS) begin
                st_next.rdata[ST_CARRY_BIT] = st_reg.carry_flag;
                st_next.rdata[ST_SKIP_BIT]  = st_reg.skip_flag;
            end else if (S_AXI_ARADDR == OFF_RETIRED) begin
                st_next.rdata[BYTE_W-1:0] = st_reg.retired;
            end else begin
                st_next.rresp = RESP_SLVERR;
            end
        end
        st_next.arready = !st_next.rvalid;
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            st_reg.aw_have                  <= 1'b0;
            st_reg.aw_addr                  <= '0;
            st_reg.w_have                   <= 1'b0;
            st_reg.w_data                   <= '0;
            st_reg.w_strb                   <= 4'h0;
            st_reg.bvalid                   <= 1'b0;
            st_reg.bresp                    <= RESP_OKAY;
            st_reg.rvalid                   <= 1'b0;
            st_reg.rdata                    <= '0;
            st_reg.rresp                    <= RESP_OKAY;
            st_reg.exec                     <= 1'b0;
            st_reg.carry_flag               <= 1'b0;
            st_reg.skip_flag                <= 1'b0;
            st_reg.awready                  <= 1'b1;
            st_reg.wready                   <= 1'b1;
            st_reg.arready                  <= 1'b1;
            st_reg.instr                    <= RST_INSTR;
            st_reg.acc                      <= RST_NIB;
            st_reg.regb                     <= RST_NIB;
            st_reg.timer2_count_bits        <= RST_BYTE;
            st_reg.timer2_low_reload_latch  <= RST_BYTE;
            st_reg.timer2_high_reload_latch <= RST_BYTE;
            st_reg.retired                  <= RST_BYTE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign S_AXI_AWREADY = st_reg.awready;
    assign S_AXI_WREADY  = st_reg.wready;
    assign S_AXI_BVALID  = st_reg.bvalid;
    assign S_AXI_BRESP   = st_reg.bresp;
    assign S_AXI_ARREADY = st_reg.arready;
    assign S_AXI_RVALID  = st_reg.rvalid;
    assign S_AXI_RDATA   = st_reg.rdata;
    assign S_AXI_RRESP   = st_reg.rresp;
endmodule

//--- tb/xfer_core_chk.sv
`timescale 1ns/1ps
module xfer_core_chk (
    input wire logic                        MCLK,
    input wire logic                        RST,
    input wire logic                        S_AXI_AWVALID,
    input wire logic                        S_AXI_AWREADY,
    input wire logic                        S_AXI_WVALID,
    input wire logic                        S_AXI_WREADY,
    input wire logic                        S_AXI_BVALID,
    input wire logic                        S_AXI_BREADY,
    input wire logic [1:0]                  S_AXI_BRESP,
    input wire logic [xfer_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic                        S_AXI_ARVALID,
    input wire logic                        S_AXI_ARREADY,
    input wire logic                        S_AXI_RVALID,
    input wire logic                        S_AXI_RREADY,
    input wire logic [xfer_pkg::DATA_W-1:0] S_AXI_RDATA
);
    import xfer_pkg::*;
    logic [7:0] ra_reg;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    // Last read address, to know what RDATA holds
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) ra_reg <= 8'h00;
        else if (S_AXI_ARVALID && S_AXI_ARREADY) ra_reg <= S_AXI_ARADDR;
    end
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write answer late");
    a_resp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
        && $stable(S_AXI_BRESP)) else $error("write response dropped");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID
        && !S_AXI_ARREADY) else $error("read answer late");
    a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
        && $stable(S_AXI_RDATA)) else $error("read data dropped");
    a_no_skip: assert property (S_AXI_RVALID && ra_reg == OFF_STATUS
        |-> !S_AXI_RDATA[ST_SKIP_BIT]) else $error("skip flag set");
    a_low_width: assert property (S_AXI_RVALID && ra_reg == OFF_LOW
        |-> S_AXI_RDATA[31:8] == 24'h00_0000) else $error("low latch wide");
    a_high_width: assert property (S_AXI_RVALID && ra_reg == OFF_HIGH
        |-> S_AXI_RDATA[31:8] == 24'h00_0000) else $error("high latch wide");
    a_acc_width: assert property (S_AXI_RVALID && ra_reg == OFF_ACC
        |-> S_AXI_RDATA[31:4] == 28'h000_0000) else $error("acc wide");
endmodule
bind xfer_core xfer_core_chk i_chk (
    .MCLK          (MCLK),
    .RST           (RST),
    .S_AXI_AWVALID (S_AXI_AWVALID),
    .S_AXI_AWREADY (S_AXI_AWREADY),
    .S_AXI_WVALID  (S_AXI_WVALID),
    .S_AXI_WREADY  (S_AXI_WREADY),
    .S_AXI_BVALID  (S_AXI_BVALID),
    .S_AXI_BREADY  (S_AXI_BREADY),
    .S_AXI_BRESP   (S_AXI_BRESP),
    .S_AXI_ARADDR  (S_AXI_ARADDR),
    .S_AXI_ARVALID (S_AXI_ARVALID),
    .S_AXI_ARREADY (S_AXI_ARREADY),
    .S_AXI_RVALID  (S_AXI_RVALID),
    .S_AXI_RREADY  (S_AXI_RREADY),
    .S_AXI_RDATA   (S_AXI_RDATA)
);

//--- tb/fetch_model.sv
`timescale 1ns/1ps
module fetch_model (
    input  wire logic [1:0] sel,
    output logic      [9:0] word
);
    import xfer_pkg::*;
    always_comb begin
        case (sel)
            2'h0: word = 10'h231;
            2'h1: word = 10'h294;
            2'h2: word = CODE_RELOAD_CNT;
            default: word = 10'h01E;
        endcase
    end
endmodule

//--- tb/timer2_reload_transfer_ops_tb.sv
`timescale 1ns/1ps
module timer2_reload_transfer_ops_tb;
    import xfer_pkg::*;
    logic        MCLK = 1'b0;
    logic        RST = 1'b1;
    logic [7:0]  S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
    logic [3:0]  S_AXI_WSTRB = 4'hF;
    logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    logic        S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
    logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    logic [1:0]  sel = 2'h0;
    logic [9:0]  word;
    int          fails = 0, n_tests = 0, cycles = 0;
    xfer_core i_dut (
        .MCLK          (MCLK),
        .RST           (RST),
        .S_AXI_AWADDR  (S_AXI_AWADDR),
        .S_AXI_AWVALID (S_AXI_AWVALID),
        .S_AXI_AWREADY (S_AXI_AWREADY),
        .S_AXI_WDATA   (S_AXI_WDATA),
        .S_AXI_WSTRB   (S_AXI_WSTRB),
        .S_AXI_WVALID  (S_AXI_WVALID),
        .S_AXI_WREADY  (S_AXI_WREADY),
        .S_AXI_BRESP   (S_AXI_BRESP),
        .S_AXI_BVALID  (S_AXI_BVALID),
        .S_AXI_BREADY  (S_AXI_BREADY),
        .S_AXI_ARADDR  (S_AXI_ARADDR),
        .S_AXI_ARVALID (S_AXI_ARVALID),
        .S_AXI_ARREADY (S_AXI_ARREADY),
        .S_AXI_RDATA   (S_AXI_RDATA),
        .S_AXI_RRESP   (S_AXI_RRESP),
        .S_AXI_RVALID  (S_AXI_RVALID),
        .S_AXI_RREADY  (S_AXI_RREADY)
    );
    fetch_model i_fetch (.sel(sel), .word(word));
    always #5 MCLK = ~MCLK;
    task automatic report_and_stop;
        $display("Counts: %0d mismatches in %0d comparisons", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Whole run needs about a hundred cycles
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_e(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge MCLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        fork
            begin do @(posedge MCLK); while (!S_AXI_AWREADY); S_AXI_AWVALID <= 1'b0; end
            begin do @(posedge MCLK); while (!S_AXI_WREADY); S_AXI_WVALID <= 1'b0; end
        join
        do @(posedge MCLK); while (!S_AXI_BVALID);
        S_AXI_BREADY <= 1'b0;
        chk({30'h0000_0000, S_AXI_BRESP}, {30'h0000_0000, er});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wr_e(a, d, RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge MCLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do @(posedge MCLK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 1'b0;
        do @(posedge MCLK); while (!S_AXI_RVALID);
        S_AXI_RREADY <= 1'b0;
        chk(S_AXI_RDATA, exp);
        chk({30'h0000_0000, S_AXI_RRESP}, {30'h0000_0000, er});
    endtask
    // Word comes from the fetch model, issued through the instruction register
    task automatic issue(input logic [1:0] s);
        sel <= s;
        // Word must follow the new select before the write takes it
        @(posedge MCLK);
        wr(OFF_INSTR, {22'h00_0000, word});
    endtask
    task automatic t_load_low;
        wr(OFF_ACC, 32'h0000_0005);
        wr(OFF_REGB, 32'h0000_000A);
        wr(OFF_STATUS, 32'h0000_0001);
        issue(2'h0);
        rd(OFF_COUNT, 32'h0000_00A5, RESP_OKAY);
        rd(OFF_LOW, 32'h0000_00A5, RESP_OKAY);
        rd(OFF_STATUS, 32'h0000_0001, RESP_OKAY);
    endtask
    task automatic t_high;
        wr(OFF_ACC, 32'h0000_0003);
        wr(OFF_REGB, 32'h0000_000C);
        issue(2'h1);
        rd(OFF_HIGH, 32'h0000_00C3, RESP_OKAY);
        rd(OFF_COUNT, 32'h0000_00A5, RESP_OKAY);
    endtask
    task automatic t_reload;
        wr(OFF_COUNT, 32'h0000_0011);
        issue(2'h2);
        rd(OFF_COUNT, 32'h0000_00A5, RESP_OKAY);
        rd(OFF_LOW, 32'h0000_00A5, RESP_OKAY);
    endtask
    task automatic t_b_to_acc;
        wr(OFF_REGB, 32'h0000_0009);
        issue(2'h3);
        rd(OFF_ACC, 32'h0000_0009, RESP_OKAY);
        rd(OFF_REGB, 32'h0000_0009, RESP_OKAY);
        rd(OFF_RETIRED, 32'h0000_0004, RESP_OKAY);
        rd(OFF_STATUS, 32'h0000_0001, RESP_OKAY);
        rd(8'h20, 32'h0000_0000, RESP_SLVERR);
        wr_e(OFF_LOW, 32'h0000_0033, RESP_OKAY);
        rd(OFF_LOW, 32'h0000_00A5, RESP_OKAY);
        wr_e(8'h20, 32'h0000_0033, RESP_SLVERR);
    endtask
    initial begin
        repeat (4) @(posedge MCLK);
        RST <= 1'b0;
        t_load_low();
        t_high();
        t_reload();
        t_b_to_acc();
        report_and_stop();
    end
endmodule
